// File: src/vpl_pkg.sv
`default_nettype none
package vpl_pkg;

  // ****************************************
  // Widths and encodings
  // ****************************************
  localparam int VW         = 16;   // Voltage and current magnitude width
  localparam int PCTW       = 8;    // Percentage width
  localparam int TW         = 16;   // Delay counter width, in ms ticks
  localparam logic [1:0] PICK_ONE   = 2'h0;
  localparam logic [1:0] PICK_TWO   = 2'h1;
  localparam logic [1:0] PICK_THREE = 2'h2;
  localparam logic [7:0] PCT_FULL   = 8'h64;  // 100 percent
  localparam logic [7:0] OV_DROP_PCT  = 8'h61; // 97 percent release point
  localparam logic [7:0] UV_DROP_PCT  = 8'h67; // 103 percent release point
  // Root three approximated as 4433 / 7678 inverse: scale by 37837 / 65536
  localparam logic [15:0] INV_ROOT3_Q16 = 16'h93CD;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ     = 40_000_000;
  localparam int TICK_US    = 1000;
  localparam int TICK_CYC   = CLK_HZ / 1_000_000 * TICK_US;

  // Element settings
  typedef struct packed {
    logic            under_mode;   // 1 undervoltage, 0 overvoltage
    logic            meas_p2p;     // Measuring mode phase to phase
    logic [1:0]      pick_rule;    // One, two or three of three
    logic [PCTW-1:0] pickup_pct;   // Threshold in percent of nominal
    logic [PCTW-1:0] dropout_pct;  // Release point in percent of threshold
    logic [TW-1:0]   trip_delay;   // Trip delay in ms ticks
  } vpl_phase_set_type;

  typedef struct packed {
    logic            under_mode;
    logic            src_calc;     // Residual source calculated
    logic            superv_only;  // Alarm only, no trip
    logic [PCTW-1:0] pickup_pct;
    logic [TW-1:0]   trip_delay;
  } vpl_resid_set_type;

  typedef enum logic [1:0] {VPL_IDLE, VPL_TIMING, VPL_TRIPPED} vpl_state_type;

endpackage
`default_nettype wire

// File: src/vpl_voltage_protection.sv
`timescale 1ns/100ps
`default_nettype none
module vpl_voltage_protection #(
  parameter int TICK_CYCLES = vpl_pkg::TICK_CYC
) (
  input  wire logic                       CORE_CLK_I,
  input  wire logic                       RST_N_I,
  input  wire logic                       CLK_EN_I,
  input  wire logic                       VT_CONNECTION_TYPE_I,   // 1 line-to-line
  input  wire logic [vpl_pkg::VW-1:0]     PHASE_VT_SECONDARY_RATING_I,
  input  wire logic [vpl_pkg::VW-1:0]     AUX_VT_SECONDARY_RATING_I,
  input  wire logic [3*vpl_pkg::VW-1:0]   PHASE_VOLT_I,
  input  wire logic [3*vpl_pkg::VW-1:0]   PHASE_CURR_I,
  input  wire logic [vpl_pkg::VW-1:0]     AUX_VOLT_I,
  input  wire logic [vpl_pkg::VW-1:0]     CALC_RESID_VOLT_I,
  input  wire vpl_pkg::vpl_phase_set_type PHASE_SET_I,
  input  wire vpl_pkg::vpl_resid_set_type RESIDUAL_SET_I,
  input  wire logic                       IMIN_CHECK_EN_I,
  input  wire logic [vpl_pkg::VW-1:0]     IMIN_LIMIT_I,
  input  wire logic [vpl_pkg::TW-1:0]     IMIN_RELEASE_DELAY_I,
  output logic [2:0]                      PHASE_ALARM_O,
  output logic                            PHASE_TRIP_O,
  output logic                            RESIDUAL_VOLTAGE_ELEMENT_ALARM_O,
  output logic                            RESIDUAL_VOLTAGE_ELEMENT_TRIP_O,
  output logic                            UV_BLOCKED_O,
  output logic                            RESID_SRC_VALID_O
);

  // Refuse a tick divider the counter cannot serve
  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least one");
  end

  localparam int W  = vpl_pkg::VW;
  localparam int PW = vpl_pkg::PCTW;

  // ****************************************
  // Millisecond tick
  // ****************************************
  logic [31:0] tick_cnt;
  logic        tick;
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      tick_cnt <= 32'h0;
      tick     <= 1'b0;
    end else if (CLK_EN_I) begin
      tick <= (tick_cnt == 32'(TICK_CYCLES - 1));
      tick_cnt <= (tick_cnt == 32'(TICK_CYCLES - 1)) ? 32'h0 : tick_cnt + 32'h1;
    end
  end

  // ****************************************
  // Nominal references
  // ****************************************
  logic          eff_p2p;
  logic [W-1:0]  phase_nom;
  logic [W-1:0]  resid_nom;
  logic          src_valid;
  logic [W-1:0]  resid_meas;
  logic [W+15:0] star_prod;
  assign eff_p2p    = VT_CONNECTION_TYPE_I | PHASE_SET_I.meas_p2p;
  assign star_prod  = PHASE_VT_SECONDARY_RATING_I * vpl_pkg::INV_ROOT3_Q16;
  assign phase_nom  = eff_p2p ? PHASE_VT_SECONDARY_RATING_I : star_prod[W+15:16];
  assign src_valid  = !(RESIDUAL_SET_I.src_calc && VT_CONNECTION_TYPE_I);
  assign resid_nom  = RESIDUAL_SET_I.src_calc ? PHASE_VT_SECONDARY_RATING_I
                                              : AUX_VT_SECONDARY_RATING_I;
  assign resid_meas = RESIDUAL_SET_I.src_calc ? CALC_RESID_VOLT_I : AUX_VOLT_I;

  // Thresholds scaled by 100: compare value*100*100 against nom*pct*drop
  logic [W+PW-1:0]    ph_thr100;
  logic [W+2*PW-1:0]  ph_drop100;
  logic [W+PW-1:0]    rs_thr100;
  logic [W+2*PW-1:0]  rs_drop100;
  logic [PW-1:0]      rs_drop_pct;
  assign ph_thr100   = phase_nom * PHASE_SET_I.pickup_pct;
  assign ph_drop100  = ph_thr100 * PHASE_SET_I.dropout_pct;
  assign rs_drop_pct = RESIDUAL_SET_I.under_mode ? vpl_pkg::UV_DROP_PCT
                                                 : vpl_pkg::OV_DROP_PCT;
  assign rs_thr100   = resid_nom * RESIDUAL_SET_I.pickup_pct;
  assign rs_drop100  = rs_thr100 * rs_drop_pct;

  // ****************************************
  // Per-phase pickup with hysteresis
  // ****************************************
  logic [2:0] ph_pick;
  logic [2:0] ph_live;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_phase
      logic [W-1:0]      v;
      logic [W+PW-1:0]   v100;
      logic [W+2*PW-1:0] v10k;
      logic              pick;
      assign ph_pick[g] = pick;
      assign v    = PHASE_VOLT_I[g*W +: W];
      assign v100 = v * vpl_pkg::PCT_FULL;
      assign v10k = v100 * vpl_pkg::PCT_FULL;
      assign ph_live[g] = PHASE_CURR_I[g*W +: W] >= IMIN_LIMIT_I;
      // Picked up holds until the release point is crossed
      always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
          pick <= 1'b0;
        end else if (CLK_EN_I) begin
          if (PHASE_SET_I.under_mode) begin
            pick <= pick ? (v10k < ph_drop100)
                         : (v100 < ph_thr100);
          end else begin
            pick <= pick ? (v10k > ph_drop100)
                         : (v100 > ph_thr100);
          end
        end
      end
    end
  endgenerate

  // Phase count vote
  logic [1:0] pick_cnt;
  logic       ph_vote;
  assign pick_cnt = 2'(ph_pick[0]) + 2'(ph_pick[1]) + 2'(ph_pick[2]);
  always_comb begin
    case (PHASE_SET_I.pick_rule)
      vpl_pkg::PICK_ONE:   ph_vote = (pick_cnt >= 2'h1);
      vpl_pkg::PICK_TWO:   ph_vote = (pick_cnt >= 2'h2);
      vpl_pkg::PICK_THREE: ph_vote = (pick_cnt == 2'h3);
      default:             ph_vote = (pick_cnt == 2'h3);
    endcase
  end

  // ****************************************
  // Minimum current block and release delay
  // ****************************************
  logic                  uv_block;
  logic [vpl_pkg::TW-1:0] rel_cnt;
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      uv_block <= 1'b0;
      rel_cnt  <= '0;
    end else if (CLK_EN_I) begin
      if (!IMIN_CHECK_EN_I || !PHASE_SET_I.under_mode) begin
        uv_block <= 1'b0;
        rel_cnt  <= '0;
      end else if (ph_live == 3'h0) begin
        uv_block <= 1'b1;
        rel_cnt  <= '0;
      end else if (uv_block) begin
        if (rel_cnt >= IMIN_RELEASE_DELAY_I) begin
          uv_block <= 1'b0;
        end else if (tick) begin
          rel_cnt <= rel_cnt + 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Residual element pickup
  // ****************************************
  logic            rs_pick;
  logic [W+PW-1:0] r100;
  logic [W+2*PW-1:0] r10k;
  assign r100 = resid_meas * vpl_pkg::PCT_FULL;
  assign r10k = r100 * vpl_pkg::PCT_FULL;
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      rs_pick <= 1'b0;
    end else if (CLK_EN_I) begin
      if (!src_valid) begin
        rs_pick <= 1'b0;
      end else if (RESIDUAL_SET_I.under_mode) begin
        rs_pick <= rs_pick ? (r10k < rs_drop100) : (r100 < rs_thr100);
      end else begin
        rs_pick <= rs_pick ? (r10k > rs_drop100) : (r100 > rs_thr100);
      end
    end
  end

  // ****************************************
  // Alarm and trip timers
  // ****************************************
  logic                   ph_act;
  logic [vpl_pkg::TW-1:0] ph_tmr;
  logic [vpl_pkg::TW-1:0] rs_tmr;
  assign ph_act = ph_vote && !(uv_block && PHASE_SET_I.under_mode);

  // Phase element alarm and trip
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      ph_tmr        <= '0;
      PHASE_ALARM_O <= 3'h0;
      PHASE_TRIP_O  <= 1'b0;
    end else if (CLK_EN_I) begin
      if (ph_act) begin
        PHASE_ALARM_O <= ph_pick;
        if (ph_tmr >= PHASE_SET_I.trip_delay) begin
          PHASE_TRIP_O <= 1'b1;
        end else if (tick) begin
          ph_tmr <= ph_tmr + 1'b1;
        end
      end else begin
        PHASE_ALARM_O <= 3'h0;
        PHASE_TRIP_O  <= 1'b0;
        ph_tmr        <= '0;
      end
    end
  end

  // Residual element alarm and trip
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      rs_tmr                           <= '0;
      RESIDUAL_VOLTAGE_ELEMENT_ALARM_O <= 1'b0;
      RESIDUAL_VOLTAGE_ELEMENT_TRIP_O  <= 1'b0;
    end else if (CLK_EN_I) begin
      if (rs_pick) begin
        RESIDUAL_VOLTAGE_ELEMENT_ALARM_O <= 1'b1;
        // Supervision-only pulls the trip down at once, expired or not
        if (rs_tmr >= RESIDUAL_SET_I.trip_delay || RESIDUAL_SET_I.superv_only) begin
          RESIDUAL_VOLTAGE_ELEMENT_TRIP_O <= !RESIDUAL_SET_I.superv_only;
        end
        if (rs_tmr < RESIDUAL_SET_I.trip_delay && tick) begin
          rs_tmr <= rs_tmr + 1'b1;
        end
      end else begin
        RESIDUAL_VOLTAGE_ELEMENT_ALARM_O <= 1'b0;
        RESIDUAL_VOLTAGE_ELEMENT_TRIP_O  <= 1'b0;
        rs_tmr                           <= '0;
      end
    end
  end

  // Status flags
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      UV_BLOCKED_O      <= 1'b0;
      RESID_SRC_VALID_O <= 1'b0;
    end else if (CLK_EN_I) begin
      UV_BLOCKED_O      <= uv_block;
      RESID_SRC_VALID_O <= src_valid;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);

  superv_no_trip_a: assert property (CLK_EN_I && RESIDUAL_SET_I.superv_only
    |=> !RESIDUAL_VOLTAGE_ELEMENT_TRIP_O)
    else $error("residual trip in supervision-only mode");
  check_off_a: assert property (CLK_EN_I && !IMIN_CHECK_EN_I |=> !uv_block)
    else $error("current block while check disabled");
  dead_block_a: assert property (CLK_EN_I && IMIN_CHECK_EN_I && PHASE_SET_I.under_mode
    && ph_live == 3'h0 |=> uv_block)
    else $error("no block with all currents dead");
  hold_block_a: assert property (uv_block && CLK_EN_I && IMIN_CHECK_EN_I
    && PHASE_SET_I.under_mode && rel_cnt < IMIN_RELEASE_DELAY_I |=> uv_block)
    else $error("block released before delay");
  drop_clear_a: assert property (CLK_EN_I && !ph_act |=> PHASE_ALARM_O == 3'h0
    && !PHASE_TRIP_O)
    else $error("alarm held after dropout");
  trip_alarm_a: assert property (PHASE_TRIP_O |-> PHASE_ALARM_O != 3'h0
    || $past(CLK_EN_I) == 1'b0)
    else $error("trip without alarm");
  ref_star_a: assert property (!VT_CONNECTION_TYPE_I && !PHASE_SET_I.meas_p2p
    |-> phase_nom < PHASE_VT_SECONDARY_RATING_I || PHASE_VT_SECONDARY_RATING_I == '0)
    else $error("star reference not reduced");
  ref_delta_a: assert property (VT_CONNECTION_TYPE_I
    |-> phase_nom == PHASE_VT_SECONDARY_RATING_I)
    else $error("line-to-line reference wrong");
  calc_valid_a: assert property (CLK_EN_I && !src_valid |=> !rs_pick)
    else $error("calculated residual used without star inputs");
  ref_resid_a: assert property (!RESIDUAL_SET_I.src_calc
    |-> resid_nom == AUX_VT_SECONDARY_RATING_I)
    else $error("residual reference wrong");

  phase_trip_c:  cover property (PHASE_TRIP_O);
  resid_trip_c:  cover property (RESIDUAL_VOLTAGE_ELEMENT_TRIP_O);
  uv_release_c:  cover property (uv_block ##1 !uv_block);
  alarm_abort_c: cover property (PHASE_ALARM_O != 3'h0 ##1 PHASE_ALARM_O == 3'h0);

endmodule
`default_nettype wire

// File: test/vpl_meas_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Upstream measurement source
// ****************************************
module vpl_meas_model (
  input  wire logic        clk_i,
  input  wire logic [47:0] volt_req_i,
  input  wire logic [47:0] curr_req_i,
  input  wire logic [15:0] aux_req_i,
  input  wire logic [15:0] calc_req_i,
  output logic [47:0]      volt_o,
  output logic [47:0]      curr_o,
  output logic [15:0]      aux_o,
  output logic [15:0]      calc_o
);
  // Measurement frame registered each rising edge, like an upstream pipeline stage
  always_ff @(posedge clk_i) begin
    volt_o <= volt_req_i;
    curr_o <= curr_req_i;
    aux_o  <= aux_req_i;
    calc_o <= calc_req_i;
  end
endmodule
`default_nettype wire

// File: test/test_vpl_voltage_protection.sv
`timescale 1ns/100ps
`default_nettype none
module test_vpl_voltage_protection;
  logic clk = 1'b0, rst_n = 1'b0, conn = 1'b0, imin_en = 1'b0;
  logic [15:0] rate_ph = 16'h03E8, rate_aux = 16'h03E8, aux = 16'h0000, calc = 16'h0000;
  logic [47:0] volt = 48'h0, curr = {3{16'h0064}};
  wire logic [47:0] volt_w, curr_w;
  wire logic [15:0] aux_w, calc_w;
  logic [2:0] alarm;
  logic trip, ralarm, rtrip, blocked, valid;
  vpl_pkg::vpl_phase_set_type ps = '{1'b0, 1'b0, 2'h0, 8'h64, 8'h5F, 16'h0003};
  vpl_pkg::vpl_resid_set_type rs = '{1'b0, 1'b0, 1'b0, 8'h32, 16'h0001};
  int errors = 0, tests_run = 0;
  // ****************************************
  // Clock, source model and block
  // ****************************************
  initial begin
    forever #12.5 clk = ~clk;
  end
  vpl_meas_model vpl_meas_model_inst (.clk_i(clk), .volt_req_i(volt), .curr_req_i(curr),
    .aux_req_i(aux), .calc_req_i(calc), .volt_o(volt_w), .curr_o(curr_w), .aux_o(aux_w),
    .calc_o(calc_w));
  vpl_voltage_protection #(.TICK_CYCLES(4)) vpl_voltage_protection_inst (.CORE_CLK_I(clk),
    .RST_N_I(rst_n), .CLK_EN_I(1'b1), .VT_CONNECTION_TYPE_I(conn),
    .PHASE_VT_SECONDARY_RATING_I(rate_ph), .AUX_VT_SECONDARY_RATING_I(rate_aux),
    .PHASE_VOLT_I(volt_w), .PHASE_CURR_I(curr_w), .AUX_VOLT_I(aux_w),
    .CALC_RESID_VOLT_I(calc_w), .PHASE_SET_I(ps), .RESIDUAL_SET_I(rs),
    .IMIN_CHECK_EN_I(imin_en), .IMIN_LIMIT_I(16'h0032), .IMIN_RELEASE_DELAY_I(16'h0003),
    .PHASE_ALARM_O(alarm), .PHASE_TRIP_O(trip), .RESIDUAL_VOLTAGE_ELEMENT_ALARM_O(ralarm),
    .RESIDUAL_VOLTAGE_ELEMENT_TRIP_O(rtrip), .UV_BLOCKED_O(blocked), .RESID_SRC_VALID_O(valid));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Wait whole cycles; drive and look at the falling edge
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  // Reference selection from connection and measuring mode, threshold 577 vs 1000
  task automatic t_nominal();
    volt = {16'h01F4, 16'h01F4, 16'h0258};
    cyc(4);
    chk("alarm star p2g", alarm, 3'h1);
    ps.meas_p2p = 1'b1;
    cyc(4);
    chk("alarm star p2p", alarm, 3'h0);
    ps.meas_p2p = 1'b0;
    conn = 1'b1;
    cyc(4);
    chk("alarm forced p2p", alarm, 3'h0);
    conn = 1'b0;
    volt = {3{16'h01F4}};
    cyc(4);
  endtask
  // Every vote rule against one, two and three raised phases
  task automatic t_vote();
    for (int r = 0; r < 3; r++) begin
      for (int n = 1; n < 4; n++) begin
        ps.pick_rule = 2'(r);
        for (int k = 0; k < 3; k++) volt[16*k +: 16] = (k < n) ? 16'h0258 : 16'h01F4;
        cyc(4);
        chk("alarm vote", alarm, (n > r) ? 3'((1 << n) - 1) : 3'h0);
        volt = {3{16'h01F4}};
        cyc(4);
      end
    end
    ps.pick_rule = vpl_pkg::PICK_ONE;
  endtask
  // Trip delay, hysteresis band 548..577, early dropout resets timer
  task automatic t_trip();
    volt[15:0] = 16'h0258;
    cyc(6);
    chk("alarm on pickup", alarm, 3'h1);
    chk("no early trip", trip, 1'b0);
    volt[15:0] = 16'h0230;
    cyc(14);
    chk("alarm in band", alarm, 3'h1);
    chk("trip after delay", trip, 1'b1);
    volt[15:0] = 16'h021C;
    cyc(4);
    chk("alarm below dropout", alarm, 3'h0);
    chk("trip cleared", trip, 1'b0);
    volt[15:0] = 16'h0258;
    cyc(6);
    volt[15:0] = 16'h01F4;
    cyc(20);
    chk("no trip after drop", trip, 1'b0);
    volt[15:0] = 16'h0258;
    cyc(6);
    chk("timer restarted", trip, 1'b0);
    volt[15:0] = 16'h01F4;
    cyc(4);
  endtask
  // Undervoltage current block and release delay, threshold 800
  task automatic t_block();
    ps = '{1'b1, 1'b1, vpl_pkg::PICK_ONE, 8'h50, 8'h69, 16'h0064};
    volt = {3{16'h02BC}};
    curr = 48'h0;
    cyc(4);
    chk("check off no block", blocked, 1'b0);
    chk("alarm unblocked", alarm, 3'h7);
    imin_en = 1'b1;
    cyc(4);
    chk("dead currents block", blocked, 1'b1);
    chk("alarm blocked", alarm, 3'h0);
    curr[31:16] = 16'h0064;
    cyc(6);
    chk("held in delay", blocked, 1'b1);
    cyc(14);
    chk("released", blocked, 1'b0);
    chk("alarm after release", alarm, 3'h7);
    curr = 48'h0;
    ps = '{1'b0, 1'b1, vpl_pkg::PICK_ONE, 8'h50, 8'h5F, 16'h0064};
    volt[15:0] = 16'h0384;
    cyc(4);
    chk("over mode unblocked", blocked, 1'b0);
    chk("over alarm", alarm, 3'h1);
    volt = {3{16'h01F4}};
    curr = {3{16'h0064}};
    imin_en = 1'b0;
    cyc(4);
  endtask
  // Residual element: sources, release points, modes, supervision only
  task automatic t_resid();
    rate_ph = 16'h07D0;
    aux = 16'h0208;
    cyc(4);
    chk("resid alarm", ralarm, 1'b1);
    aux = 16'h01EA;
    cyc(8);
    chk("hold above 97", ralarm, 1'b1);
    chk("resid trip", rtrip, 1'b1);
    aux = 16'h01E0;
    cyc(4);
    chk("release below 97", ralarm, 1'b0);
    rs.superv_only = 1'b1;
    aux = 16'h0208;
    cyc(16);
    chk("superv alarm", ralarm, 1'b1);
    chk("superv no trip", rtrip, 1'b0);
    rs = '{1'b0, 1'b1, 1'b0, 8'h32, 16'h0001};
    calc = 16'h02BC;
    cyc(4);
    chk("calc ref phase rating", ralarm, 1'b0);
    calc = 16'h044C;
    cyc(4);
    chk("calc alarm", ralarm, 1'b1);
    conn = 1'b1;
    cyc(4);
    chk("calc invalid", valid, 1'b0);
    chk("calc no alarm", ralarm, 1'b0);
    conn = 1'b0;
    rs = '{1'b1, 1'b0, 1'b0, 8'h32, 16'h0001};
    aux = 16'h01E0;
    cyc(4);
    chk("under alarm", ralarm, 1'b1);
    aux = 16'h01FE;
    cyc(4);
    chk("hold below 103", ralarm, 1'b1);
    aux = 16'h0208;
    cyc(4);
    chk("release above 103", ralarm, 1'b0);
  endtask
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    cyc(4);
    rst_n = 1'b1;
    cyc(2);
    chk("valid after reset", valid, 1'b1);
    t_nominal();
    t_vote();
    t_trip();
    t_block();
    t_resid();
    print_verdict();
  end
  initial begin
    #(25 * 5000);
    errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
